// ### tb/cam_front_test.sv
// Self-checking bench for the camera parallel capture front end
`timescale 1ns/1ps
`default_nettype none
module cam_front_test;
  import cam_pkg::*;
  logic clk_sys, rst_n, power_down_n, osc_mode_strap, pixel_clk;
  logic [DATA_W-1:0] pixel_data, payload_data;
  logic line_sync, frame_sync, reg_wr, reg_rd, aux_out2_clock_out;
  logic [ADDR_W-1:0] reg_addr;
  logic [REG_W-1:0] reg_wdata, reg_rdata;
  logic [AUX_N-1:0] remote_io, lv, x;
  logic [1:0] aux_out_low_pair, sel;
  logic aux_pin3_clock_in_i, aux_pin3_clock_in_o, aux_pin3_clock_in_oe;
  logic payload_line_sync, payload_frame_sync, payload_valid;
  logic mode12_m, edge_m, prev;
  logic [13:0] exp_q[$];
  logic [13:0] e;
  int seed, mismatches, n_checks, r, cnt;

  cam_front dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .power_down_n(power_down_n), .osc_mode_strap(osc_mode_strap),
    .pixel_clk(pixel_clk), .pixel_data(pixel_data),
    .line_sync(line_sync), .frame_sync(frame_sync),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .remote_io(remote_io),
    .aux_out_low_pair(aux_out_low_pair),
    .aux_out2_clock_out(aux_out2_clock_out),
    .aux_pin3_clock_in_i(aux_pin3_clock_in_i),
    .aux_pin3_clock_in_o(aux_pin3_clock_in_o),
    .aux_pin3_clock_in_oe(aux_pin3_clock_in_oe),
    .payload_data(payload_data), .payload_line_sync(payload_line_sync),
    .payload_frame_sync(payload_frame_sync),
    .payload_valid(payload_valid));
  sensor_model sensor (.pixel_clk(pixel_clk), .pixel_data(pixel_data),
    .line_sync(line_sync), .frame_sync(frame_sync));

  // System clock, 8 ns period
  always #4 clk_sys = ~clk_sys;

  // Compare one value and count it
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Register write, one strobe cycle
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // Register read, data looked at in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] xp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    check("reg_rdata", reg_rdata, xp);
  endtask

  // One pixel period with its expected word noted first
  task automatic pix(input logic ls, input logic fs);
    logic [DATA_W-1:0] a, b, w;
    r = $random(seed);
    a = r[11:0];
    b = r[27:16];
    w = edge_m ? b : a;
    if (!mode12_m) w[11:10] = 2'b00;
    exp_q.push_back({fs, ls, w});
    sensor.send(a, b, ls, fs);
    repeat (6) @(posedge clk_sys);
  endtask

  // Each payload word is matched against the oldest note
  always @(negedge clk_sys) begin
    if (payload_valid === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("spare_word", 16'h1, 16'h0);
      end else begin
        e = exp_q.pop_front();
        check("payload", {payload_frame_sync, payload_line_sync,
                          payload_data}, e);
      end
    end
  end

  // Watchdog against a hang
  initial begin
    #100000;
    mismatches++;
    results();
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    power_down_n = 1'b1;
    osc_mode_strap = 1'b0;
    aux_pin3_clock_in_i = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    remote_io = '0;
    seed = 95066;
    mode12_m = 1'b1;
    edge_m = 1'b0;
    repeat (12) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(ADDR_EDGE, 8'h00);
    rd(ADDR_MODE, 8'h01);
    rd(ADDR_AUX_SEL, 8'h00);
    rd(ADDR_LOCAL, 8'h00);
    rd(ADDR_STATUS, 8'h00);
    rd(8'h40, 8'h00);
    $display("test reset values done");
    // Full width, line sync toggling every word, frame sync every second word
    for (int i = 0; i < 8; i++) pix(i[0], i[1]);
    rd(ADDR_STATUS, 8'h00);
    wr(ADDR_EDGE, 8'h01);
    edge_m = 1'b1;
    // Line sync ends low, so narrow mode starts with no fresh toggle
    for (int i = 0; i < 4; i++) pix(~i[0], 1'b0);
    rd(ADDR_EDGE, 8'h01);
    $display("test capture edges done");
    // Narrow mode, source keeps ten strobes between toggles
    wr(ADDR_MODE, 8'h00);
    mode12_m = 1'b0;
    for (int i = 0; i < 20; i++) pix(i >= 10, i >= 10);
    rd(ADDR_STATUS, 8'h00);
    pix(1'b0, 1'b1);
    pix(1'b1, 1'b1);
    rd(ADDR_STATUS, 8'h02);
    wr(ADDR_STATUS, 8'h02);
    rd(ADDR_STATUS, 8'h00);
    pix(1'b1, 1'b0);
    pix(1'b1, 1'b1);
    rd(ADDR_STATUS, 8'h04);
    $display("test narrow mode done");
    // Aux sources: remote, local, clock code without oscillator
    for (int s = 0; s < 6; s++) begin
      sel = s / 2;
      r = $random(seed);
      lv = r[3:0];
      wr(ADDR_AUX_SEL, {4{sel}});
      wr(ADDR_LOCAL, {4'h0, lv});
      @(posedge clk_sys);
      remote_io <= r[7:4];
      repeat (3) @(posedge clk_sys);
      @(negedge clk_sys);
      x = (sel == SEL_REMOTE) ? r[7:4] : lv;
      check("aux", {aux_pin3_clock_in_o, aux_out2_clock_out,
                    aux_out_low_pair}, x);
      check("aux3_oe", aux_pin3_clock_in_oe, 1'b1);
    end
    $display("test aux select done");
    // Power down with strap for oscillator mode
    @(posedge clk_sys);
    osc_mode_strap <= 1'b1;
    power_down_n <= 1'b0;
    repeat (8) @(posedge clk_sys);
    @(negedge clk_sys);
    check("pd_aux", {aux_pin3_clock_in_oe, aux_pin3_clock_in_o,
                     aux_out2_clock_out, aux_out_low_pair}, 5'h00);
    @(posedge clk_sys);
    power_down_n <= 1'b1;
    repeat (5) @(posedge clk_sys);
    rd(ADDR_EDGE, 8'h00);
    rd(ADDR_MODE, 8'h01);
    rd(ADDR_AUX_SEL, 8'h00);
    rd(ADDR_LOCAL, 8'h00);
    rd(ADDR_STATUS, 8'h01);
    wr(ADDR_AUX_SEL, {SEL_CLOCK, SEL_CLOCK, 4'h0});
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check("aux3_oe", aux_pin3_clock_in_oe, 1'b0);
    cnt = 0;
    prev = aux_out2_clock_out;
    for (int j = 0; j < 108; j++) begin
      @(posedge clk_sys);
      aux_pin3_clock_in_i <= (j < 96) && (j % 12 < 6);
      @(negedge clk_sys);
      if (aux_out2_clock_out !== prev) cnt++;
      prev = aux_out2_clock_out;
    end
    check("clock_out_toggles", cnt[15:0], 16'd8);
    $display("test oscillator mode done");
    r = exp_q.size();
    check("words_left", r[15:0], 16'h0);
    results();
  end
endmodule
`default_nettype wire

// ### tb/sensor_model.sv
// Image sensor model driving the parallel pixel bus
`timescale 1ns/1ps
`default_nettype none
module sensor_model (
  output logic pixel_clk,
  output logic [cam_pkg::DATA_W-1:0] pixel_data,
  output logic line_sync,
  output logic frame_sync
);
  import cam_pkg::*;
  // Pixel clock stands still low between words
  initial begin
    pixel_clk = 1'b0;
    pixel_data = '0;
    line_sync = 1'b0;
    frame_sync = 1'b0;
  end
  // One pixel period: word a around the rise, word b around the fall
  // Sync levels hold over the whole period, so both edges see them
  task automatic send(input logic [DATA_W-1:0] a,
                      input logic [DATA_W-1:0] b,
                      input logic ls, input logic fs);
    pixel_data = a;
    line_sync = ls;
    frame_sync = fs;
    #31.25 pixel_clk = 1'b1;
    #31.25 pixel_data = b;
    #31.25 pixel_clk = 1'b0;
    #31.25 pixel_data = ~b; // Data no longer valid after the fall
  endtask
endmodule
`default_nettype wire

// ### verilog/cam_capture.sv
// Pixel word capture with sync toggle spacing monitor
`timescale 1ns/1ps
`default_nettype none
module cam_capture (
  input wire logic clk_sys,
  input wire logic rst_n,
  pix_if.cap px
);
  import cam_pkg::*;

  logic [DATA_W-1:0] word_q, word_d;
  logic ls_q, ls_d, fs_q, fs_d, valid_q, valid_d;
  logic [SYNC_N-1:0] prev_q, prev_d, viol_q, viol_d, sync_now;
  logic [CNT_W-1:0] cnt_q [SYNC_N];
  logic [CNT_W-1:0] cnt_d [SYNC_N];

  assign sync_now = {px.fs_in, px.ls_in};
  assign px.word = word_q;
  assign px.ls = ls_q;
  assign px.fs = fs_q;
  assign px.valid = valid_q;
  assign px.viol = viol_q;

  // One word per active strobe, upper bits masked in narrow mode
  always_comb begin
    word_d = word_q;
    ls_d = ls_q;
    fs_d = fs_q;
    valid_d = 1'b0;
    prev_d = prev_q;
    if (px.strobe) begin
      valid_d = 1'b1;
      if (px.mode12) begin
        word_d = px.din;
      end else begin
        word_d = {{(DATA_W-NARROW_W){1'b0}}, px.din[NARROW_W-1:0]};
      end
      ls_d = px.ls_in;
      fs_d = px.fs_in;
      prev_d = sync_now;
    end
  end

  // Per sync line: strobes since last toggle, sticky spacing violation
  for (genvar g = 0; g < SYNC_N; g++) begin : g_sync
    always_comb begin
      cnt_d[g] = cnt_q[g];
      viol_d[g] = viol_q[g] & ~px.viol_clr[g];
      if (px.strobe) begin
        if (sync_now[g] != prev_q[g]) begin
          cnt_d[g] = CNT_W'(1);
          if (!px.mode12 && cnt_q[g] < CNT_W'(SYNC_MIN_CYC)) begin
            viol_d[g] = 1'b1;
          end
        end else if (cnt_q[g] < CNT_W'(SYNC_MIN_CYC)) begin
          cnt_d[g] = cnt_q[g] + CNT_W'(1);
        end
      end
    end
    always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
        cnt_q[g] <= CNT_W'(SYNC_MIN_CYC);
      end else begin
        cnt_q[g] <= cnt_d[g];
      end
    end
  end

  // Capture registers
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      word_q <= '0;
      ls_q <= 1'b0;
      fs_q <= 1'b0;
      valid_q <= 1'b0;
      prev_q <= '0;
      viol_q <= '0;
    end else begin
      word_q <= word_d;
      ls_q <= ls_d;
      fs_q <= fs_d;
      valid_q <= valid_d;
      prev_q <= prev_d;
      viol_q <= viol_d;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_narrow_mask: assert property (px.strobe && !px.mode12 |=>
    word_q[DATA_W-1:NARROW_W] == '0 && valid_q)
    else $error("upper bits not masked in narrow mode");
  chk_wide_word: assert property (px.strobe && px.mode12 |=>
    word_q == $past(px.din))
    else $error("wide word not captured whole");
  chk_sync_raw: assert property (px.strobe |=>
    ls_q == $past(px.ls_in) && fs_q == $past(px.fs_in))
    else $error("sync bits altered");
  chk_valid_cause: assert property (valid_q |-> $past(px.strobe))
    else $error("word presented without strobe");
  chk_word_hold: assert property (!px.strobe |=> $stable(word_q))
    else $error("word changed without strobe");
  cov_narrow: cover property (px.strobe && !px.mode12);
  cov_viol: cover property ($rose(viol_q[0]));
endmodule
`default_nettype wire

// ### verilog/cam_front.sv
// Camera parallel input front end with register port and aux outputs
// How it works
// - In 10-bit mode only data inputs 0..9 are captured, 10 and 11 read as 0.
// - In 12-bit mode all twelve data inputs are captured on each strobe.
// - In 12-bit mode line and frame sync pass unchanged with no spacing limit.
// - Bit 0 of register 0x03 picks the pixel clock edge that samples the inputs.
// - Aux outputs 0 and 1 follow the remote line or a local register bit.
// - Aux output 2 follows remote line 2, a local bit, or a clock out in oscillator mode that only toggles while aux pin 3 is also on the clock code.
// - Aux pin 3 follows remote line 3, a local bit, or is a clock input in oscillator mode.
// - While power_down_n is low the block idles and all registers except the strap status bit return to defaults.
// - A strap caught during power down selects imager clock or external oscillator mode.
//
// Implementation choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cam_front (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic power_down_n,
  input wire logic osc_mode_strap,
  input wire logic pixel_clk,
  input wire logic [cam_pkg::DATA_W-1:0] pixel_data,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic [cam_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cam_pkg::REG_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [cam_pkg::REG_W-1:0] reg_rdata,
  input wire logic [cam_pkg::AUX_N-1:0] remote_io,
  output logic [1:0] aux_out_low_pair,
  output logic aux_out2_clock_out,
  input wire logic aux_pin3_clock_in_i,
  output logic aux_pin3_clock_in_o,
  output logic aux_pin3_clock_in_oe,
  output logic [cam_pkg::DATA_W-1:0] payload_data,
  output logic payload_line_sync,
  output logic payload_frame_sync,
  output logic payload_valid
);
  import cam_pkg::*;

  localparam int SYN_W = DATA_W + 6;

  pix_if px ();

  logic [SYN_W-1:0] raw_in, sync1_q, sync2_q;
  logic pclk_s, ls_s, fs_s, clkin_s, pd_n_s, strap_s;
  logic [DATA_W-1:0] din_s;
  logic run_n;
  logic pclk_prev_q, clkin_prev_q;
  logic edge_sel_q, edge_sel_d, mode12_q, mode12_d;
  logic ext_osc_q, ext_osc_d;
  logic [REG_W-1:0] aux_sel_q, aux_sel_d;
  logic [AUX_N-1:0] local_q, local_d;
  logic [REG_W-1:0] rdata_q, rdata_d;
  logic [SYNC_N-1:0] viol_clr;
  logic [1:0] low_q, low_d;
  logic aux2_q, aux2_d, aux3_o_q, aux3_o_d, aux3_oe_q, aux3_oe_d;
  logic clkout_q, clkout_d;
  logic [1:0] sel0, sel1, sel2, sel3;
  logic clkin_rise;

  // Two-stage synchroniser for every pin from outside the clock domain
  assign raw_in = {osc_mode_strap, power_down_n, aux_pin3_clock_in_i,
                   frame_sync, line_sync, pixel_clk, pixel_data};
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end
  assign din_s = sync2_q[DATA_W-1:0];
  assign pclk_s = sync2_q[DATA_W];
  assign ls_s = sync2_q[DATA_W+1];
  assign fs_s = sync2_q[DATA_W+2];
  assign clkin_s = sync2_q[DATA_W+3];
  assign pd_n_s = sync2_q[DATA_W+4];
  assign strap_s = sync2_q[DATA_W+5];

  // Power down holds the block in reset, except the synchroniser and strap capture
  assign run_n = rst_n & pd_n_s;

  // Previous clock levels for edge detection
  always_ff @(posedge clk_sys) begin
    if (!run_n) begin
      pclk_prev_q <= 1'b0;
      clkin_prev_q <= 1'b0;
    end else begin
      pclk_prev_q <= pclk_s;
      clkin_prev_q <= clkin_s;
    end
  end

  // Strobe on the selected pixel clock edge
  assign px.strobe = edge_sel_q ? (pclk_prev_q & ~pclk_s)
                                : (pclk_s & ~pclk_prev_q);
  assign px.mode12 = mode12_q;
  assign px.din = din_s;
  assign px.ls_in = ls_s;
  assign px.fs_in = fs_s;
  assign px.viol_clr = viol_clr;

  cam_capture u_capture (
    .clk_sys (clk_sys),
    .rst_n (run_n),
    .px (px)
  );

  assign payload_data = px.word;
  assign payload_line_sync = px.ls;
  assign payload_frame_sync = px.fs;
  assign payload_valid = px.valid;

  // Register writes, reads and strap capture
  always_comb begin
    edge_sel_d = edge_sel_q;
    mode12_d = mode12_q;
    aux_sel_d = aux_sel_q;
    local_d = local_q;
    rdata_d = '0;
    viol_clr = '0;
    ext_osc_d = ext_osc_q;
    if (reg_wr) begin
      if (reg_addr == ADDR_EDGE) begin
        edge_sel_d = reg_wdata[EDGE_BIT];
      end else if (reg_addr == ADDR_MODE) begin
        mode12_d = reg_wdata[MODE12_BIT];
      end else if (reg_addr == ADDR_AUX_SEL) begin
        aux_sel_d = reg_wdata;
      end else if (reg_addr == ADDR_LOCAL) begin
        local_d = reg_wdata[AUX_N-1:0];
      end else if (reg_addr == ADDR_STATUS) begin
        viol_clr = {reg_wdata[ST_VIOL_FS_BIT], reg_wdata[ST_VIOL_LS_BIT]};
      end
    end
    if (reg_rd) begin
      if (reg_addr == ADDR_EDGE) begin
        rdata_d[EDGE_BIT] = edge_sel_q;
      end else if (reg_addr == ADDR_MODE) begin
        rdata_d[MODE12_BIT] = mode12_q;
      end else if (reg_addr == ADDR_AUX_SEL) begin
        rdata_d = aux_sel_q;
      end else if (reg_addr == ADDR_LOCAL) begin
        rdata_d[AUX_N-1:0] = local_q;
      end else if (reg_addr == ADDR_STATUS) begin
        rdata_d[ST_EXT_OSC_BIT] = ext_osc_q;
        rdata_d[ST_VIOL_LS_BIT] = px.viol[0];
        rdata_d[ST_VIOL_FS_BIT] = px.viol[1];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_osc_q <= 1'b0;
    end else if (!pd_n_s) begin
      ext_osc_q <= strap_s;
    end else begin
      ext_osc_q <= ext_osc_d;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!run_n) begin
      edge_sel_q <= EDGE_RST;
      mode12_q <= MODE12_RST;
      aux_sel_q <= AUX_SEL_RST;
      local_q <= LOCAL_RST;
      rdata_q <= '0;
    end else begin
      edge_sel_q <= edge_sel_d;
      mode12_q <= mode12_d;
      aux_sel_q <= aux_sel_d;
      local_q <= local_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  // Aux pin source selection
  assign sel0 = aux_sel_q[1:0];
  assign sel1 = aux_sel_q[3:2];
  assign sel2 = aux_sel_q[5:4];
  assign sel3 = aux_sel_q[7:6];
  assign clkin_rise = clkin_s & ~clkin_prev_q;

  always_comb begin
    low_d[0] = (sel0 == SEL_REMOTE) ? remote_io[0] : local_q[0];
    low_d[1] = (sel1 == SEL_REMOTE) ? remote_io[1] : local_q[1];
    clkout_d = clkout_q;
    aux3_oe_d = 1'b1;
    aux3_o_d = (sel3 == SEL_REMOTE) ? remote_io[3] : local_q[3];
    if (ext_osc_q && sel3 == SEL_CLOCK) begin
      aux3_oe_d = 1'b0;
      aux3_o_d = 1'b0;
      if (clkin_rise) begin
        clkout_d = ~clkout_q;
      end
    end
    if (ext_osc_q && sel2 == SEL_CLOCK) begin
      aux2_d = clkout_q;
    end else if (sel2 == SEL_REMOTE) begin
      aux2_d = remote_io[2];
    end else begin
      aux2_d = local_q[2];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!run_n) begin
      low_q <= '0;
      aux2_q <= 1'b0;
      aux3_o_q <= 1'b0;
      aux3_oe_q <= 1'b0;
      clkout_q <= 1'b0;
    end else begin
      low_q <= low_d;
      aux2_q <= aux2_d;
      aux3_o_q <= aux3_o_d;
      aux3_oe_q <= aux3_oe_d;
      clkout_q <= clkout_d;
    end
  end
  assign aux_out_low_pair = low_q;
  assign aux_out2_clock_out = aux2_q;
  assign aux_pin3_clock_in_o = aux3_o_q;
  assign aux_pin3_clock_in_oe = aux3_oe_q;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  chk_edge_rise: assert property (!edge_sel_q && pclk_s && !pclk_prev_q
    |=> payload_valid)
    else $error("rising edge not captured");
  chk_edge_fall: assert property (edge_sel_q && pclk_s && !pclk_prev_q
    |=> !payload_valid)
    else $error("rising edge captured in falling mode");
  chk_pd_defaults: assert property (!pd_n_s |=> edge_sel_q == EDGE_RST
    && aux_sel_q == AUX_SEL_RST && !payload_valid && !aux3_oe_q)
    else $error("registers not at default in power down");
  chk_low_remote: assert property (pd_n_s && sel0 == SEL_REMOTE
    && $stable(sel0) |=> aux_out_low_pair[0] == $past(remote_io[0]))
    else $error("aux 0 not following remote line");
  chk_aux2_clock: assert property (run_n && ext_osc_q && sel2 == SEL_CLOCK
    |=> aux_out2_clock_out == $past(clkout_q))
    else $error("aux 2 not carrying clock out");
  chk_aux3_input: assert property (run_n && ext_osc_q && sel3 == SEL_CLOCK
    |=> !aux_pin3_clock_in_oe)
    else $error("aux 3 driven while used as clock input");
  chk_strap_take: assert property (!pd_n_s |=> ext_osc_q == $past(strap_s))
    else $error("strap not caught during power down");
  cov_fall_edge: cover property (edge_sel_q && payload_valid);
  cov_ext_clock: cover property (ext_osc_q && sel2 == SEL_CLOCK && clkin_rise);
  cov_status_read: cover property (reg_rd && reg_addr == ADDR_STATUS);
endmodule
`default_nettype wire

// ### verilog/cam_pkg.sv
// Shared constants for the camera parallel capture front end
package cam_pkg;
  localparam int DATA_W = 12;
  localparam int NARROW_W = 10;
  localparam int ADDR_W = 8;
  localparam int REG_W = 8;
  localparam int AUX_N = 4;
  localparam int SYNC_N = 2;
  localparam int SYNC_MIN_CYC = 10;
  localparam int CNT_W = 4;
  // Register indices; byte address is four times the index
  localparam logic [ADDR_W-1:0] IDX_EDGE = 8'h03;
  localparam logic [ADDR_W-1:0] IDX_MODE = 8'h05;
  localparam logic [ADDR_W-1:0] IDX_AUX_SEL = 8'h0d;
  localparam logic [ADDR_W-1:0] IDX_LOCAL = 8'h0e;
  localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h0f;
  localparam logic [ADDR_W-1:0] ADDR_EDGE = 8'h0c;
  localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h14;
  localparam logic [ADDR_W-1:0] ADDR_AUX_SEL = 8'h34;
  localparam logic [ADDR_W-1:0] ADDR_LOCAL = 8'h38;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h3c;
  // Field positions
  localparam int EDGE_BIT = 0;
  localparam int MODE12_BIT = 0;
  localparam int ST_EXT_OSC_BIT = 0;
  localparam int ST_VIOL_LS_BIT = 1;
  localparam int ST_VIOL_FS_BIT = 2;
  // Reset values
  localparam logic EDGE_RST = 1'b0;
  localparam logic MODE12_RST = 1'b1;
  localparam logic [REG_W-1:0] AUX_SEL_RST = 8'h00;
  localparam logic [AUX_N-1:0] LOCAL_RST = 4'h0;
  // Aux source select codes, two bits per aux pin
  localparam logic [1:0] SEL_REMOTE = 2'h0;
  localparam logic [1:0] SEL_LOCAL = 2'h1;
  localparam logic [1:0] SEL_CLOCK = 2'h2;
endpackage

// ### verilog/pix_if.sv
// Carrier between register/top logic and the capture unit
`timescale 1ns/1ps
`default_nettype none
interface pix_if;
  import cam_pkg::*;
  logic strobe;
  logic mode12;
  logic [DATA_W-1:0] din;
  logic ls_in;
  logic fs_in;
  logic [SYNC_N-1:0] viol_clr;
  logic [DATA_W-1:0] word;
  logic ls;
  logic fs;
  logic valid;
  logic [SYNC_N-1:0] viol;
  modport cap (input strobe, mode12, din, ls_in, fs_in, viol_clr,
               output word, ls, fs, valid, viol);
  modport ctl (output strobe, mode12, din, ls_in, fs_in, viol_clr,
               input word, ls, fs, valid, viol);
endinterface
`default_nettype wire
